// ===== hw/nvm_pe_defines.vh
// Register map, field positions and constants of the flash/EEPROM controller
`ifndef NVM_PE_DEFINES_VH
`define NVM_PE_DEFINES_VH

// Register addresses on the SFR bus
`define ADR_MODE_SEL 8'hEA
`define ADR_CONTROL 8'hEB
`define ADR_STATUS 8'hEC
`define ADR_TIME 8'hED
`define ADR_ADDR_LOW 8'hF2
`define ADR_ADDR_MID 8'hF3
`define ADR_ADDR_HIGH 8'hF4
`define ADR_DATA 8'hF5

// Reset values
`define RST_MODE_SEL 8'h00
`define RST_CONTROL 8'h03
`define RST_STATUS 8'h80
`define RST_BYTE 8'h00

// Mode select fields
`define MS_FLASH 7
`define MS_EEP 6
`define MS_PROGRAM 5
`define MS_ERASE 4
`define MS_PBUF 3
`define MS_OTP 2
`define MS_VERIFY 1
`define MS_PE_EN 0

// Control fields
`define CT_BULK_FLASH 7
`define CT_BULK_EEP 6
`define CT_EXIT_HI 5
`define CT_EXIT_LO 4
`define CT_WRITE 3
`define CT_READ 2
`define CT_CTRL_RST_N 1
`define CT_PBUF_RST_N 0
`define CT_PULSE_MASK 8'h3C
`define CT_IDLE_HIGH 8'h03

// Status fields
`define ST_DONE 7
`define ST_VFY_PASS 6
`define ST_IRQ 3
`define ST_WRITE 2
`define ST_ERASE 1
`define ST_VERIFY 0

// Unlock sequence
`define UNLOCK_FIRST 8'hA5
`define UNLOCK_SECOND 8'h5A

// Timer
`define PRESCALE_BITS 7
`define PRESCALE_LAST 7'h7F
`define TIMER_BITS 10
`define TIMER_ZERO 10'h000

// Page geometry
`define FLASH_PAGE_BITS 7
`define EEP_PAGE_BITS 4
`define FLASH_PAGE_LAST 8'h7F
`define EEP_PAGE_LAST 8'h0F
`define ERASED_BYTE 8'hFF

`endif

// ===== hw/pe_timer.v
// Program/erase timer: divide-by-128 prescaler and 10-bit tick counter
`timescale 1ns/100ps
`default_nettype none
`include "nvm_pe_defines.vh"

module pe_timer #(
    parameter CNT_W = 10
) (
    // Clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // Control
    input wire start_in,
    input wire abort_in,
    input wire [CNT_W-1:0] limit_in,
    // Status
    output reg busy_out,
    output wire done_out
);

reg [`PRESCALE_BITS-1:0] pre_r;
reg [CNT_W-1:0] cnt_r;
wire tick;

assign tick = busy_out && (pre_r == `PRESCALE_LAST);
assign done_out = tick && (cnt_r == limit_in);

always @(posedge clk_sys_in) begin
    if (!rst_n_in || abort_in) begin
        busy_out <= 1'b0;
        pre_r <= {`PRESCALE_BITS{1'b0}};
        cnt_r <= {CNT_W{1'b0}};
    end else if (start_in) begin
        busy_out <= 1'b1;
        pre_r <= {`PRESCALE_BITS{1'b0}};
        cnt_r <= {CNT_W{1'b0}};
    end else if (busy_out) begin
        pre_r <= pre_r + 1'b1;
        if (done_out) begin
            busy_out <= 1'b0;
        end else if (tick) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
end

endmodule
`default_nettype wire

// ===== hw/eep_unlock.v
// Two-write unlock sequence detector for EEPROM program/erase
`timescale 1ns/100ps
`default_nettype none
`include "nvm_pe_defines.vh"

module eep_unlock (
    // Clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // Data register writes
    input wire data_wr_in,
    input wire [7:0] data_in,
    input wire lock_in,
    // State
    output reg unlocked_out
);

reg first_seen_r;

always @(posedge clk_sys_in) begin
    if (!rst_n_in || lock_in) begin
        first_seen_r <= 1'b0;
        unlocked_out <= 1'b0;
    end else if (data_wr_in) begin
        first_seen_r <= (data_in == `UNLOCK_FIRST);
        if (first_seen_r && data_in == `UNLOCK_SECOND) begin
            unlocked_out <= 1'b1;
        end
    end
end

endmodule
`default_nettype wire

// ===== hw/nvm_pe_ctrl.v
// Flash and data EEPROM program/erase/verify controller with SFR registers
`timescale 1ns/100ps
`default_nettype none
`include "nvm_pe_defines.vh"

module nvm_pe_ctrl #(
    parameter ADDR_W = 24
) (
    // Clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // SFR bus
    input wire [7:0] sfr_addr_in,
    input wire [7:0] sfr_wdata_in,
    input wire sfr_wr_in,
    input wire sfr_rd_in,
    output reg [7:0] sfr_rdata_out,
    // Memory array side
    input wire [7:0] nvm_rdata_in,
    input wire [7:0] nvm_expect_in,
    output reg [ADDR_W-1:0] nvm_addr_out,
    output reg [7:0] nvm_wdata_out,
    output reg nvm_rd_out,
    output reg nvm_wr_out,
    output reg nvm_program_out,
    output reg nvm_erase_out,
    output reg nvm_bulk_out,
    output reg nvm_flash_sel_out,
    output reg nvm_eep_sel_out,
    output reg nvm_otp_sel_out,
    output reg nvm_pbuf_sel_out,
    output reg nvm_pbuf_rst_out,
    output reg exit_pgm_out,
    output reg nvm_irq_out
);

// ============================================================
// States
localparam S_IDLE = 5'b00001;
localparam S_TIMED = 5'b00010;
localparam S_VFY_RD = 5'b00100;
localparam S_VFY_CMP = 5'b01000;
localparam S_DIRECT = 5'b10000;

// ============================================================
// Registers
reg [7:0] mode_sel_r;
reg [7:0] control_r;
reg [7:0] time_setting_r;
reg [ADDR_W-1:0] addr_r;
reg [7:0] data_r;
reg [23:0] cksum_r;
reg op_done_flag_r;
reg verify_pass_flag_r;
reg nvm_irq_flag_r;
reg [4:0] state_r;
reg [7:0] vfy_left_r;
reg bulk_r;

wire wr_mode_sel;
wire wr_control;
wire wr_status;
wire wr_time;
wire wr_addr_low;
wire wr_addr_mid;
wire wr_addr_high;
wire wr_data;
wire pe_enable;
wire write_mode_flag;
wire erase_mode_flag;
wire verify_mode_flag;
wire any_mode;
wire eep_unlocked;
wire target_ok;
wire start_write;
wire start_read;
wire launch_pe;
wire launch_bulk;
wire launch_vfy;
wire ctrl_reset;
wire timer_busy;
wire timer_done;
wire [`TIMER_BITS-1:0] timer_limit;
wire [ADDR_W-1:0] page_mask;
wire [7:0] vfy_last;
wire [7:0] nvm_status;
wire [7:0] expect_byte;
wire op_finish;

assign wr_mode_sel = sfr_wr_in && (sfr_addr_in == `ADR_MODE_SEL);
assign wr_control = sfr_wr_in && (sfr_addr_in == `ADR_CONTROL);
assign wr_status = sfr_wr_in && (sfr_addr_in == `ADR_STATUS);
assign wr_time = sfr_wr_in && (sfr_addr_in == `ADR_TIME);
assign wr_addr_low = sfr_wr_in && (sfr_addr_in == `ADR_ADDR_LOW);
assign wr_addr_mid = sfr_wr_in && (sfr_addr_in == `ADR_ADDR_MID);
assign wr_addr_high = sfr_wr_in && (sfr_addr_in == `ADR_ADDR_HIGH);
assign wr_data = sfr_wr_in && (sfr_addr_in == `ADR_DATA);

// ============================================================
// Mode decode
// enable gates modes
assign pe_enable = mode_sel_r[`MS_PE_EN];
assign verify_mode_flag = pe_enable && mode_sel_r[`MS_VERIFY] &&
    (mode_sel_r[`MS_PROGRAM] || mode_sel_r[`MS_ERASE]);
assign write_mode_flag = pe_enable && mode_sel_r[`MS_PROGRAM] &&
    !mode_sel_r[`MS_VERIFY];
assign erase_mode_flag = pe_enable && mode_sel_r[`MS_ERASE] &&
    !mode_sel_r[`MS_VERIFY];
assign any_mode = write_mode_flag || erase_mode_flag || verify_mode_flag;

assign target_ok = mode_sel_r[`MS_FLASH] ||
    (mode_sel_r[`MS_EEP] && eep_unlocked);

assign start_write = control_r[`CT_WRITE];
assign start_read = control_r[`CT_READ];
assign ctrl_reset = !control_r[`CT_CTRL_RST_N];

assign launch_bulk = (state_r == S_IDLE) && start_write && erase_mode_flag &&
    ((control_r[`CT_BULK_FLASH] && mode_sel_r[`MS_FLASH]) ||
     (control_r[`CT_BULK_EEP] && mode_sel_r[`MS_EEP] && eep_unlocked));
assign launch_pe = (state_r == S_IDLE) && start_write && target_ok &&
    (write_mode_flag || erase_mode_flag);
assign launch_vfy = (state_r == S_IDLE) && start_read && verify_mode_flag;

assign timer_limit = (launch_bulk || bulk_r) ? {time_setting_r, 2'b11} :
    {1'b0, time_setting_r, 1'b1};

assign page_mask = mode_sel_r[`MS_FLASH] ?
    ({ADDR_W{1'b1}} << `FLASH_PAGE_BITS) :
    ({ADDR_W{1'b1}} << `EEP_PAGE_BITS);
assign vfy_last = mode_sel_r[`MS_FLASH] ? `FLASH_PAGE_LAST : `EEP_PAGE_LAST;
assign expect_byte = mode_sel_r[`MS_ERASE] ? `ERASED_BYTE : nvm_expect_in;

assign op_finish = timer_done ||
    ((state_r == S_VFY_CMP) && (vfy_left_r == 8'h00));

assign nvm_status = {op_done_flag_r, verify_pass_flag_r, 2'b00,
    nvm_irq_flag_r, write_mode_flag, erase_mode_flag, verify_mode_flag};

// ============================================================
// Submodules
pe_timer #(
    .CNT_W(`TIMER_BITS)
) u_timer (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .start_in(launch_pe || launch_bulk),
    .abort_in(ctrl_reset),
    .limit_in(timer_limit),
    .busy_out(timer_busy),
    .done_out(timer_done)
);

eep_unlock u_unlock (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .data_wr_in(wr_data),
    .data_in(sfr_wdata_in),
    .lock_in(exit_pgm_out || ctrl_reset),
    .unlocked_out(eep_unlocked)
);

// ============================================================
// Software registers
always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
        mode_sel_r <= `RST_MODE_SEL;
        control_r <= `RST_CONTROL;
        time_setting_r <= `RST_BYTE;
        data_r <= `RST_BYTE;
    end else begin
        if (wr_mode_sel) begin
            mode_sel_r <= sfr_wdata_in;
        end
        if (wr_control) begin
            control_r <= sfr_wdata_in;
        end else begin
            control_r <= (control_r & ~`CT_PULSE_MASK) | `CT_IDLE_HIGH;
        end
        if (wr_time) begin
            time_setting_r <= sfr_wdata_in;
        end
        if (wr_data) begin
            data_r <= sfr_wdata_in;
        end else if (state_r == S_DIRECT) begin
            data_r <= nvm_rdata_in;
        end
    end
end

// ============================================================
// Address and checksum
always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
        addr_r <= {ADDR_W{1'b0}};
        cksum_r <= 24'h000000;
    end else begin
        if (wr_addr_low) begin
            addr_r[7:0] <= sfr_wdata_in;
        end else if (state_r == S_VFY_CMP) begin
            addr_r <= addr_r + 1'b1;
        end
        if (wr_addr_mid) begin
            addr_r[15:8] <= sfr_wdata_in;
        end
        if (wr_addr_high) begin
            addr_r[ADDR_W-1:16] <= sfr_wdata_in[ADDR_W-17:0];
        end
        if (mode_sel_r[`MS_PBUF] && !control_r[`CT_PBUF_RST_N]) begin
            cksum_r <= 24'h000000;
        end else if (state_r == S_VFY_CMP) begin
            cksum_r <= cksum_r + {16'h0000, nvm_rdata_in};
        end
    end
end

// ============================================================
// Sequencer and status flags
always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
        state_r <= S_IDLE;
        vfy_left_r <= 8'h00;
        bulk_r <= 1'b0;
        op_done_flag_r <= 1'b1;
        verify_pass_flag_r <= 1'b0;
        nvm_irq_flag_r <= 1'b0;
    end else if (ctrl_reset) begin
        state_r <= S_IDLE;
        bulk_r <= 1'b0;
        op_done_flag_r <= 1'b1;
    end else begin
        case (state_r)
            S_IDLE: begin
                if (launch_pe || launch_bulk) begin
                    state_r <= S_TIMED;
                    bulk_r <= launch_bulk;
                end else if (launch_vfy) begin
                    state_r <= S_VFY_RD;
                    vfy_left_r <= vfy_last;
                end else if (start_read && !any_mode) begin
                    state_r <= S_DIRECT;
                end
            end
            S_TIMED: begin
                if (!timer_busy) begin
                    state_r <= S_IDLE;
                    bulk_r <= 1'b0;
                end
            end
            S_VFY_RD: begin
                state_r <= S_VFY_CMP;
            end
            S_VFY_CMP: begin
                vfy_left_r <= vfy_left_r - 1'b1;
                if (vfy_left_r == 8'h00) begin
                    state_r <= S_IDLE;
                end else begin
                    state_r <= S_VFY_RD;
                end
            end
            S_DIRECT: begin
                state_r <= S_IDLE;
            end
            default: begin
                state_r <= S_IDLE;
            end
        endcase
        // done clears at start, sets at end
        if (launch_pe || launch_bulk || launch_vfy) begin
            op_done_flag_r <= 1'b0;
        end else if (op_finish) begin
            op_done_flag_r <= 1'b1;
        end
        if (launch_vfy) begin
            verify_pass_flag_r <= 1'b1;
        end else if (state_r == S_VFY_CMP && nvm_rdata_in != expect_byte) begin
            verify_pass_flag_r <= 1'b0;
        end else if (wr_status) begin
            verify_pass_flag_r <= sfr_wdata_in[`ST_VFY_PASS];
        end
        if (op_finish) begin
            nvm_irq_flag_r <= 1'b1;
        end else if (wr_status) begin
            nvm_irq_flag_r <= sfr_wdata_in[`ST_IRQ];
        end
    end
end

// ============================================================
// Memory strobes
always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
        nvm_addr_out <= {ADDR_W{1'b0}};
        nvm_wdata_out <= `RST_BYTE;
        nvm_rd_out <= 1'b0;
        nvm_wr_out <= 1'b0;
        nvm_program_out <= 1'b0;
        nvm_erase_out <= 1'b0;
        nvm_bulk_out <= 1'b0;
        nvm_flash_sel_out <= 1'b0;
        nvm_eep_sel_out <= 1'b0;
        nvm_otp_sel_out <= 1'b0;
        nvm_pbuf_sel_out <= 1'b0;
        nvm_pbuf_rst_out <= 1'b0;
        exit_pgm_out <= 1'b0;
        nvm_irq_out <= 1'b0;
    end else begin
        if (state_r == S_TIMED || launch_pe || launch_bulk) begin
            nvm_addr_out <= addr_r & page_mask;
        end else begin
            nvm_addr_out <= addr_r;
        end
        nvm_wdata_out <= data_r;
        nvm_rd_out <= (state_r == S_VFY_RD) ||
            ((state_r == S_IDLE) && start_read && !any_mode);
        nvm_wr_out <= (state_r == S_IDLE) && start_write && !any_mode;
        nvm_program_out <= timer_busy && !ctrl_reset &&
            mode_sel_r[`MS_PROGRAM];
        nvm_erase_out <= timer_busy && !ctrl_reset &&
            mode_sel_r[`MS_ERASE];
        nvm_bulk_out <= timer_busy && !ctrl_reset && bulk_r;
        nvm_flash_sel_out <= mode_sel_r[`MS_FLASH];
        nvm_eep_sel_out <= mode_sel_r[`MS_EEP];
        nvm_otp_sel_out <= mode_sel_r[`MS_OTP];
        nvm_pbuf_sel_out <= mode_sel_r[`MS_PBUF];
        nvm_pbuf_rst_out <= !mode_sel_r[`MS_PBUF] &&
            !control_r[`CT_PBUF_RST_N];
        exit_pgm_out <= control_r[`CT_EXIT_HI] && control_r[`CT_EXIT_LO];
        nvm_irq_out <= nvm_irq_flag_r;
    end
end

// ============================================================
// Read mux
always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
        sfr_rdata_out <= `RST_BYTE;
    end else if (sfr_rd_in) begin
        if (sfr_addr_in == `ADR_MODE_SEL) begin
            sfr_rdata_out <= mode_sel_r;
        end else if (sfr_addr_in == `ADR_CONTROL) begin
            sfr_rdata_out <= control_r;
        end else if (sfr_addr_in == `ADR_STATUS) begin
            sfr_rdata_out <= nvm_status;
        end else if (sfr_addr_in == `ADR_TIME) begin
            sfr_rdata_out <= time_setting_r;
        end else if (sfr_addr_in == `ADR_ADDR_LOW) begin
            sfr_rdata_out <= cksum_r[7:0];
        end else if (sfr_addr_in == `ADR_ADDR_MID) begin
            sfr_rdata_out <= cksum_r[15:8];
        end else if (sfr_addr_in == `ADR_ADDR_HIGH) begin
            sfr_rdata_out <= cksum_r[23:16];
        end else if (sfr_addr_in == `ADR_DATA) begin
            sfr_rdata_out <= data_r;
        end else begin
            sfr_rdata_out <= `RST_BYTE;
        end
    end
end

endmodule
`default_nettype wire

// ===== tb/nvm_pe_ctrl_assertions.sv
// Port-level assertions for the flash/EEPROM program/erase controller
`timescale 1ns/100ps
`default_nettype none
module nvm_pe_ctrl_assertions #(
    parameter ADDR_W = 24
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // SFR bus
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_rdata_out,
    // Array side
    input wire logic [ADDR_W-1:0] nvm_addr_out,
    input wire logic [7:0] nvm_wdata_out,
    input wire logic nvm_rd_out,
    input wire logic nvm_wr_out,
    input wire logic nvm_program_out,
    input wire logic nvm_erase_out,
    input wire logic nvm_bulk_out,
    input wire logic nvm_flash_sel_out,
    input wire logic nvm_eep_sel_out,
    input wire logic nvm_irq_out
);
    logic [7:0] mode_r;
    logic [7:0] time_r;
    logic [7:0] data_r;
    logic [19:0] cnt_r;
    logic busy;
    logic ctl_wr;
    logic idle_pe;
    logic [19:0] page_cyc;
    assign busy = nvm_program_out | nvm_erase_out;
    assign ctl_wr = sfr_wr_in && sfr_addr_in == 8'hEB && !busy;
    assign idle_pe = mode_r[5:4] == 2'b00 && !mode_r[1] && mode_r[0];
    assign page_cyc = ({12'h000, time_r} + 20'h00001) << 8;
    // ========================================
    // Shadow registers and busy length
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            mode_r <= 8'h00;
            time_r <= 8'h00;
            data_r <= 8'h00;
            cnt_r <= 20'h00000;
        end else begin
            if (sfr_wr_in && sfr_addr_in == 8'hEA) mode_r <= sfr_wdata_in;
            if (sfr_wr_in && sfr_addr_in == 8'hED) time_r <= sfr_wdata_in;
            if (sfr_wr_in && sfr_addr_in == 8'hF5) data_r <= sfr_wdata_in;
            cnt_r <= busy ? cnt_r + 20'h00001 : 20'h00000;
        end
    end
    default clocking dc @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    // ========================================
    // Assertions
    a_page_duration: assert property (
        $fell(busy) && !$past(nvm_bulk_out) |-> cnt_r == page_cyc)
        else $error("page operation length wrong");
    a_bulk_duration: assert property (
        $fell(busy) && $past(nvm_bulk_out) |-> cnt_r == (page_cyc << 1))
        else $error("bulk erase length wrong");
    a_page_addr_mask: assert property (
        busy && !nvm_bulk_out |-> !(nvm_flash_sel_out && |nvm_addr_out[6:0])
        && !(nvm_eep_sel_out && |nvm_addr_out[3:0]))
        else $error("page offset bits not dropped");
    a_status_busy_read: assert property (
        (sfr_rd_in && sfr_addr_in == 8'hEC && nvm_program_out)
        ##1 (!sfr_rd_in && nvm_program_out) ##1 nvm_program_out
        |-> !sfr_rdata_out[7])
        else $error("done flag set while busy");
    a_irq_on_done: assert property (
        $fell(busy) |-> nvm_irq_out)
        else $error("no interrupt at completion");
    a_start_launch: assert property (
        ctl_wr && sfr_wdata_in[3] && sfr_wdata_in[1] && mode_r[7]
        && mode_r[5] && mode_r[0] && !mode_r[1]
        |-> ##[1:3] nvm_program_out)
        else $error("start bit did not launch program");
    a_disabled_blocks: assert property (
        ctl_wr && sfr_wdata_in[3] && !mode_r[0] |-> ##1 (!busy)[*6])
        else $error("program ran with enable low");
    a_direct_write: assert property (
        ctl_wr && sfr_wdata_in == 8'h0B && idle_pe
        |-> ##[1:3] (nvm_wr_out && nvm_wdata_out == data_r))
        else $error("direct write missing");
    a_direct_read: assert property (
        ctl_wr && sfr_wdata_in == 8'h07 && idle_pe |-> ##[1:3] nvm_rd_out)
        else $error("direct read missing");
    a_verify_step: assert property (
        nvm_rd_out && mode_r[1] ##2 nvm_rd_out
        |-> nvm_addr_out == $past(nvm_addr_out, 2) + 1'b1)
        else $error("verify address did not step by one");
endmodule
bind nvm_pe_ctrl nvm_pe_ctrl_assertions #(.ADDR_W(ADDR_W)) u_nvm_chk (
    .clk_sys_in, .rst_n_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in,
    .sfr_rd_in, .sfr_rdata_out, .nvm_addr_out, .nvm_wdata_out, .nvm_rd_out,
    .nvm_wr_out, .nvm_program_out, .nvm_erase_out, .nvm_bulk_out,
    .nvm_flash_sel_out, .nvm_eep_sel_out, .nvm_irq_out
);
`default_nettype wire

// ===== tb/nvm_array_model.sv
// Behavioural byte array standing behind the controller's array port
`timescale 1ns/100ps
`default_nettype none
module nvm_array_model (
    // Clock
    input wire logic clk_sys_in,
    // Array strobes
    input wire logic [23:0] nvm_addr_in,
    input wire logic [7:0] nvm_wdata_in,
    input wire logic nvm_rd_in,
    input wire logic nvm_wr_in,
    input wire logic corrupt_in,
    // Read data
    output logic [7:0] nvm_rdata_out,
    output logic [7:0] nvm_expect_out
);
    logic [7:0] mem [0:255];
    logic [7:0] last_r;
    logic [7:0] flip;
    assign flip = (corrupt_in && nvm_addr_in[3:0] == 4'h5) ? 8'h01 : 8'h00;
    // Answer within the strobe cycle; idle port shows the inverse
    assign nvm_rdata_out = nvm_rd_in ? mem[nvm_addr_in[7:0]] : ~last_r;
    assign nvm_expect_out = nvm_rd_in ? (mem[nvm_addr_in[7:0]] ^ flip) :
        ~last_r;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = i[7:0] ^ 8'h3C;
        end
        last_r = 8'h00;
    end
    always @(posedge clk_sys_in) begin
        if (nvm_rd_in) last_r <= mem[nvm_addr_in[7:0]];
        if (nvm_wr_in) mem[nvm_addr_in[7:0]] <= nvm_wdata_in;
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the flash/EEPROM program/erase controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_sys_in;
    logic rst_n_in;
    logic [7:0] sfr_addr_in;
    logic [7:0] sfr_wdata_in;
    logic sfr_wr_in;
    logic sfr_rd_in;
    logic corrupt;
    wire [7:0] sfr_rdata_out;
    wire [7:0] nvm_rdata_in;
    wire [7:0] nvm_expect_in;
    wire [23:0] nvm_addr_out;
    wire [7:0] nvm_wdata_out;
    wire nvm_rd_out, nvm_wr_out, nvm_program_out, nvm_erase_out;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int pe_cnt = 0;
    int pe_len = 0;
    logic [23:0] pe_addr = 24'h000000;
    logic [7:0] rv;
    logic [23:0] sum;
    nvm_pe_ctrl dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
        .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
        .sfr_rdata_out(sfr_rdata_out), .nvm_rdata_in(nvm_rdata_in),
        .nvm_expect_in(nvm_expect_in), .nvm_addr_out(nvm_addr_out),
        .nvm_wdata_out(nvm_wdata_out), .nvm_rd_out(nvm_rd_out),
        .nvm_wr_out(nvm_wr_out), .nvm_program_out(nvm_program_out),
        .nvm_erase_out(nvm_erase_out), .nvm_bulk_out(),
        .nvm_flash_sel_out(), .nvm_eep_sel_out(), .nvm_otp_sel_out(),
        .nvm_pbuf_sel_out(), .nvm_pbuf_rst_out(), .exit_pgm_out(),
        .nvm_irq_out()
    );
    nvm_array_model u_mem (
        .clk_sys_in(clk_sys_in), .nvm_addr_in(nvm_addr_out),
        .nvm_wdata_in(nvm_wdata_out), .nvm_rd_in(nvm_rd_out),
        .nvm_wr_in(nvm_wr_out), .corrupt_in(corrupt),
        .nvm_rdata_out(nvm_rdata_in), .nvm_expect_out(nvm_expect_in)
    );
    // ========================================
    // Clock, timeout and busy length
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            end_sim;
        end
    end
    always @(posedge clk_sys_in) begin
        if (nvm_program_out | nvm_erase_out) begin
            pe_cnt <= pe_cnt + 1;
            pe_addr <= nvm_addr_out;
        end else begin
            if (pe_cnt != 0) pe_len <= pe_cnt;
            pe_cnt <= 0;
        end
    end
    // ========================================
    // Bus and compare tasks
    task automatic end_sim;
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        sfr_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_in);
        sfr_addr_in <= a;
        sfr_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        sfr_rd_in <= 1'b0;
        #1;
        rv = sfr_rdata_out;
    endtask
    task automatic wait_done;
        int k;
        k = 0;
        rv = 8'h00;
        while (rv[7] !== 1'b1 && k < 4000) begin
            rd(8'hEC);
            k++;
        end
        chk(rv[7], 1'b1);
        repeat (3) @(posedge clk_sys_in);
    endtask
    task automatic idle_chk;
        repeat (6) @(posedge clk_sys_in);
        chk(nvm_program_out | nvm_erase_out, 0);
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset_values;
        rd(8'hEC);
        chk(rv, 8'h80);
        wr(8'hF2, 8'h5A);
        rd(8'hF2);
        chk(rv, 8'h00);
        wr(8'hED, 8'hC3);
        rd(8'hED);
        chk(rv, 8'hC3);
    endtask
    task automatic t_page_program;
        wr(8'hEA, 8'hA1);
        wr(8'hF2, 8'hB5);
        wr(8'hF3, 8'h12);
        wr(8'hF4, 8'h00);
        wr(8'hED, 8'h02);
        wr(8'hEB, 8'h0B);
        rd(8'hEC);
        chk(rv[7], 0);
        rd(8'hEB);
        chk(rv, 8'h03);
        wait_done;
        chk(rv & 8'h88, 8'h88);
        chk(pe_len, 3 * 2 * 128);
        chk(pe_addr, 24'h001280);
    endtask
    task automatic t_bulk_erase;
        wr(8'hEA, 8'h91);
        wr(8'hED, 8'h01);
        wr(8'hEB, 8'h8B);
        wait_done;
        chk(pe_len, 2 * 4 * 128);
    endtask
    task automatic t_eep_unlock;
        wr(8'hED, 8'h00);
        wr(8'hEA, 8'hA0);
        wr(8'hEB, 8'h0B);
        idle_chk;
        wr(8'hEA, 8'h61);
        wr(8'hEB, 8'h0B);
        idle_chk;
        wr(8'hF5, 8'h5A);
        wr(8'hF5, 8'hA5);
        wr(8'hEB, 8'h0B);
        idle_chk;
        wr(8'hF5, 8'hA5);
        wr(8'hF5, 8'h5A);
        wr(8'hF2, 8'h37);
        wr(8'hF3, 8'h01);
        wr(8'hEB, 8'h0B);
        wait_done;
        chk(pe_len, 2 * 128);
        chk(pe_addr, 24'h000130);
    endtask
    task automatic t_verify(input logic bad);
        corrupt <= bad;
        wr(8'hEA, 8'hA3);
        wr(8'hF2, 8'h00);
        wr(8'hF3, 8'h01);
        wr(8'hF4, 8'h00);
        wr(8'hEB, 8'h07);
        wait_done;
        chk(rv[6], !bad);
        corrupt <= 1'b0;
    endtask
    task automatic t_checksum;
        sum = 24'h000000;
        for (int i = 0; i < 128; i++) begin
            sum = sum + (i[7:0] ^ 8'h3C);
        end
        rd(8'hF2);
        chk(rv, sum[7:0]);
        rd(8'hF3);
        chk(rv, sum[15:8]);
        rd(8'hF4);
        chk(rv, sum[23:16]);
    endtask
    task automatic t_direct;
        wr(8'hEA, 8'h81);
        wr(8'hF2, 8'h42);
        wr(8'hF3, 8'h00);
        wr(8'hF5, 8'hC7);
        wr(8'hEB, 8'h0B);
        repeat (4) @(posedge clk_sys_in);
        wr(8'hF5, 8'h00);
        wr(8'hEB, 8'h07);
        repeat (4) @(posedge clk_sys_in);
        rd(8'hF5);
        chk(rv, 8'hC7);
    endtask
    initial begin
        rst_n_in = 1'b0;
        sfr_addr_in = 8'h00;
        sfr_wdata_in = 8'h00;
        sfr_wr_in = 1'b0;
        sfr_rd_in = 1'b0;
        corrupt = 1'b0;
        repeat (16) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        t_reset_values;
        t_page_program;
        t_bulk_erase;
        t_eep_unlock;
        t_verify(1'b0);
        t_checksum;
        t_verify(1'b1);
        t_direct;
        end_sim;
    end
endmodule
`default_nettype wire
